// file: rtl/stop_cfg_pkg.sv
// shared constants and types for the stop ramp and stop option configuration
package stop_cfg_pkg;

	// object dictionary indices and subindices
	localparam logic [15:0] IDX_QS_RAMP    = 16'h604A;
	localparam logic [15:0] IDX_SPEED_UNIT = 16'h604C;
	localparam logic [15:0] IDX_QS_OPT     = 16'h605A;
	localparam logic [15:0] IDX_SD_OPT     = 16'h605B;
	localparam logic [15:0] IDX_DIS_OPT    = 16'h605C;
	localparam logic [7:0]  SUB_COUNT      = 8'h00;
	localparam logic [7:0]  SUB_FIRST      = 8'h01;
	localparam logic [7:0]  SUB_SECOND     = 8'h02;

	// reset values
	localparam logic [7:0]  ENTRY_COUNT    = 8'h02;
	localparam logic [31:0] RST_QS_SPEED   = 32'h00001388;
	localparam logic [15:0] RST_QS_TIME    = 16'h0001;
	localparam logic [31:0] RST_UNIT_MUL   = 32'h00000001;
	localparam logic [31:0] RST_UNIT_DIV   = 32'h0000003C;
	localparam logic [15:0] RST_OPT        = 16'h0001;

	// option code values
	localparam logic [15:0] OPT_IMMEDIATE  = 16'h0000;
	localparam logic [15:0] OPT_SLOW       = 16'h0001;
	localparam logic [15:0] OPT_QUICK      = 16'h0002;

	// power state machine transitions reported to the block
	localparam logic [1:0]  TRANS_QUICKSTOP = 2'h0;
	localparam logic [1:0]  TRANS_SHUTDOWN  = 2'h1;
	localparam logic [1:0]  TRANS_DISABLE   = 2'h2;

	// entry decode
	localparam logic [3:0]  ENT_NONE       = 4'h0;
	localparam logic [3:0]  ENT_QS_COUNT   = 4'h1;
	localparam logic [3:0]  ENT_QS_SPEED   = 4'h2;
	localparam logic [3:0]  ENT_QS_TIME    = 4'h3;
	localparam logic [3:0]  ENT_UNIT_COUNT = 4'h4;
	localparam logic [3:0]  ENT_UNIT_MUL   = 4'h5;
	localparam logic [3:0]  ENT_UNIT_DIV   = 4'h6;
	localparam logic [3:0]  ENT_QS_OPT     = 4'h7;
	localparam logic [3:0]  ENT_SD_OPT     = 4'h8;
	localparam logic [3:0]  ENT_DIS_OPT    = 4'h9;

	// non-volatile image slots
	localparam int          NV_WORDS       = 7;
	localparam logic [2:0]  NV_QS_SPEED    = 3'h0;
	localparam logic [2:0]  NV_QS_TIME     = 3'h1;
	localparam logic [2:0]  NV_UNIT_MUL    = 3'h2;
	localparam logic [2:0]  NV_UNIT_DIV    = 3'h3;
	localparam logic [2:0]  NV_QS_OPT      = 3'h4;
	localparam logic [2:0]  NV_SD_OPT      = 3'h5;
	localparam logic [2:0]  NV_DIS_OPT     = 3'h6;

	// divider length
	localparam logic [6:0]  DIV_STEPS      = 7'h40;

	typedef enum logic [1:0] {
		stop_immediate,
		stop_slow_ramp,
		stop_quick_ramp
	} stop_kind_type;

	typedef enum logic [1:0] {
		div_idle,
		div_run,
		div_finish
	} div_state_type;

endpackage

// file: rtl/speed_unit_scale.sv
// sequential scaling of an internal speed by multiplier over divisor
`timescale 1ns/1ps
module speed_unit_scale (
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic               start,
	input  wire logic signed [31:0] speed_in,
	input  wire logic signed [31:0] multiplier,
	input  wire logic signed [31:0] divisor,
	output logic                    busy,
	output logic                    done,
	output logic [31:0]             result,
	output logic                    div_fault,
	output logic                    in_rpm
);

	function automatic logic [63:0] abs64(input logic signed [63:0] v);
		abs64 = v[63] ? 64'(-v) : 64'(v);
	endfunction

	stop_cfg_pkg::div_state_type state;
	logic [63:0] quo;
	logic [31:0] rem;
	logic [31:0] den;
	logic        neg;
	logic [6:0]  steps;
	logic [32:0] trial;
	logic        unit_rpm;

	assign unit_rpm = (multiplier == 32'sh00000001) && (divisor == 32'sh00000001);
	assign trial    = {rem, quo[63]};
	assign busy     = (state != stop_cfg_pkg::div_idle);
	assign in_rpm   = unit_rpm; // R5

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state     <= stop_cfg_pkg::div_idle;
			quo       <= 64'h0000000000000000;
			rem       <= 32'h00000000;
			den       <= 32'h00000000;
			neg       <= 1'b0;
			steps     <= 7'h00;
			done      <= 1'b0;
			result    <= 32'h00000000;
			div_fault <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				stop_cfg_pkg::div_idle: begin
					if (start) begin
						if (unit_rpm) begin
							// both factors one: value already in revolutions per minute
							result    <= speed_in; // R5
							div_fault <= 1'b0;
							done      <= 1'b1;
						end else if (divisor == 32'sh00000000) begin
							result    <= 32'h00000000;
							div_fault <= 1'b1;
							done      <= 1'b1;
						end else begin
							quo   <= abs64(64'(speed_in) * 64'(multiplier)); // R6
							neg   <= speed_in[31] ^ multiplier[31] ^ divisor[31];
							den   <= 32'(abs64(64'(divisor)));
							rem   <= 32'h00000000;
							steps <= stop_cfg_pkg::DIV_STEPS;
							state <= stop_cfg_pkg::div_run;
						end
					end
				end
				stop_cfg_pkg::div_run: begin
					if (trial >= {1'b0, den}) begin
						rem <= 32'(trial - {1'b0, den}); // R6
						quo <= {quo[62:0], 1'b1};
					end else begin
						rem <= 32'(trial);
						quo <= {quo[62:0], 1'b0};
					end
					steps <= 7'(steps - 7'h01);
					if (steps == 7'h01) begin
						state <= stop_cfg_pkg::div_finish;
					end
				end
				stop_cfg_pkg::div_finish: begin
					// quotient truncated to 32 bits; overflow is not flagged
					result    <= neg ? 32'(-quo[31:0]) : quo[31:0];
					div_fault <= 1'b0;
					done      <= 1'b1;
					state     <= stop_cfg_pkg::div_idle;
				end
				default: begin
					state <= stop_cfg_pkg::div_idle;
				end
			endcase
		end
	end

endmodule

// file: rtl/drive_stop_ramp_option_config.sv
// stop ramp, speed unit and stop option entries with stop action selection
`timescale 1ns/1ps
// Summary of operation
// R1: quick-stop ramp decelerates quick-stop in velocity mode
// R2: ramps are speed step over time step
// R3: ramp speed step u32 rw, reset 1388h
// R4: ramp time step u16 rw, reset 0001h
// R5: both scaling factors one means rpm
// R6: otherwise scale by multiplier, divide by divisor
// R7: scaling factors s32 rw, reset 1 and 3Ch
// R8: quick-stop option s16, reset 1, 0 immediate
// R9: quick-stop option 1 slow, 2 quick, then disabled
// R10: shutdown option: 0 immediate, 1 slow then disabled
// R11: disable option s16 rw, reset 1, not mappable
// R12: parameters save and restore as application set
// R13: disable option: 0 immediate, 1 slow then disabled
// R14: reserved option writes rejected, value kept
module drive_stop_ramp_option_config (
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	input  wire logic                      od_valid,
	input  wire logic                      od_write,
	input  wire logic                      od_pdo,
	input  wire logic [15:0]               od_index,
	input  wire logic [7:0]                od_subindex,
	input  wire logic [31:0]               od_wdata,
	output logic                           od_ack,
	output logic                           od_abort,
	output logic [31:0]                    od_rdata,
	input  wire logic                      save_store,
	input  wire logic                      save_restore,
	output logic                           save_done,
	input  wire logic                      psm_event,
	input  wire logic [1:0]                psm_transition,
	input  wire logic                      velocity_mode,
	input  wire logic [31:0]               mode_slow_speed,
	input  wire logic [15:0]               mode_slow_time,
	input  wire logic [31:0]               mode_quick_speed,
	input  wire logic [15:0]               mode_quick_time,
	output logic                           stop_valid,
	output stop_cfg_pkg::stop_kind_type    stop_kind,
	output logic                           stop_to_disabled,
	output logic [31:0]                    decel_speed_step,
	output logic [15:0]                    decel_time_step,
	input  wire logic                      speed_start,
	input  wire logic signed [31:0]        speed_internal,
	output logic                           speed_busy,
	output logic                           speed_valid,
	output logic [31:0]                    speed_user,
	output logic                           speed_fault,
	output logic                           speed_in_rpm
);

	// option range check shared by writes and restores
	function automatic logic option_ok(input logic [3:0] ent, input logic [15:0] v);
		if (ent == stop_cfg_pkg::ENT_QS_OPT) begin
			option_ok = (v == stop_cfg_pkg::OPT_IMMEDIATE) || (v == stop_cfg_pkg::OPT_SLOW)
				|| (v == stop_cfg_pkg::OPT_QUICK);
		end else begin
			option_ok = (v == stop_cfg_pkg::OPT_IMMEDIATE) || (v == stop_cfg_pkg::OPT_SLOW);
		end
	endfunction

	logic [31:0] qs_speed_step;
	logic [15:0] qs_time_step;
	logic [31:0] unit_multiplier;
	logic [31:0] unit_divisor;
	logic [15:0] qs_option;
	logic [15:0] sd_option;
	logic [15:0] dis_option;
	logic [31:0] nv_image [0:stop_cfg_pkg::NV_WORDS-1];

	logic [3:0]  entry;
	logic        entry_ro;
	logic        entry_mappable;
	logic        value_ok;
	logic        wr_take;
	logic [31:0] next_rdata;
	logic        restore_ok;

	// entry decode
	always_comb begin
		entry = stop_cfg_pkg::ENT_NONE;
		case (od_index)
			stop_cfg_pkg::IDX_QS_RAMP: begin
				case (od_subindex)
					stop_cfg_pkg::SUB_COUNT:  entry = stop_cfg_pkg::ENT_QS_COUNT;
					stop_cfg_pkg::SUB_FIRST:  entry = stop_cfg_pkg::ENT_QS_SPEED;
					stop_cfg_pkg::SUB_SECOND: entry = stop_cfg_pkg::ENT_QS_TIME;
					default:                  entry = stop_cfg_pkg::ENT_NONE;
				endcase
			end
			stop_cfg_pkg::IDX_SPEED_UNIT: begin
				case (od_subindex)
					stop_cfg_pkg::SUB_COUNT:  entry = stop_cfg_pkg::ENT_UNIT_COUNT;
					stop_cfg_pkg::SUB_FIRST:  entry = stop_cfg_pkg::ENT_UNIT_MUL;
					stop_cfg_pkg::SUB_SECOND: entry = stop_cfg_pkg::ENT_UNIT_DIV;
					default:                  entry = stop_cfg_pkg::ENT_NONE;
				endcase
			end
			stop_cfg_pkg::IDX_QS_OPT: begin
				if (od_subindex == stop_cfg_pkg::SUB_COUNT) begin
					entry = stop_cfg_pkg::ENT_QS_OPT;
				end
			end
			stop_cfg_pkg::IDX_SD_OPT: begin
				if (od_subindex == stop_cfg_pkg::SUB_COUNT) begin
					entry = stop_cfg_pkg::ENT_SD_OPT;
				end
			end
			stop_cfg_pkg::IDX_DIS_OPT: begin
				if (od_subindex == stop_cfg_pkg::SUB_COUNT) begin
					entry = stop_cfg_pkg::ENT_DIS_OPT;
				end
			end
			default: entry = stop_cfg_pkg::ENT_NONE;
		endcase
	end

	assign entry_ro = (entry == stop_cfg_pkg::ENT_QS_COUNT)
		|| (entry == stop_cfg_pkg::ENT_UNIT_COUNT);
	// only ramp and scaling values travel in received process data
	assign entry_mappable = (entry == stop_cfg_pkg::ENT_QS_SPEED)
		|| (entry == stop_cfg_pkg::ENT_QS_TIME) || (entry == stop_cfg_pkg::ENT_UNIT_MUL)
		|| (entry == stop_cfg_pkg::ENT_UNIT_DIV); // R11
	assign value_ok = ((entry != stop_cfg_pkg::ENT_QS_OPT) && (entry != stop_cfg_pkg::ENT_SD_OPT)
		&& (entry != stop_cfg_pkg::ENT_DIS_OPT)) || option_ok(entry, od_wdata[15:0]); // R14
	assign wr_take = od_valid && od_write && (entry != stop_cfg_pkg::ENT_NONE) && !entry_ro
		&& value_ok && (!od_pdo || entry_mappable);

	// a corrupt image must not load reserved codes into the option entries
	assign restore_ok = option_ok(stop_cfg_pkg::ENT_QS_OPT, nv_image[stop_cfg_pkg::NV_QS_OPT][15:0])
		&& option_ok(stop_cfg_pkg::ENT_SD_OPT, nv_image[stop_cfg_pkg::NV_SD_OPT][15:0])
		&& option_ok(stop_cfg_pkg::ENT_DIS_OPT, nv_image[stop_cfg_pkg::NV_DIS_OPT][15:0]); // R14

	// ramp entries
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			qs_speed_step <= stop_cfg_pkg::RST_QS_SPEED; // R3
			qs_time_step  <= stop_cfg_pkg::RST_QS_TIME; // R4
		end else if (save_restore && restore_ok) begin
			qs_speed_step <= nv_image[stop_cfg_pkg::NV_QS_SPEED]; // R12
			qs_time_step  <= nv_image[stop_cfg_pkg::NV_QS_TIME][15:0];
		end else if (wr_take) begin
			if (entry == stop_cfg_pkg::ENT_QS_SPEED) begin
				qs_speed_step <= od_wdata; // R3
			end
			if (entry == stop_cfg_pkg::ENT_QS_TIME) begin
				qs_time_step <= od_wdata[15:0]; // R4
			end
		end
	end

	// scaling entries
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			unit_multiplier <= stop_cfg_pkg::RST_UNIT_MUL; // R7
			unit_divisor    <= stop_cfg_pkg::RST_UNIT_DIV; // R7
		end else if (save_restore && restore_ok) begin
			unit_multiplier <= nv_image[stop_cfg_pkg::NV_UNIT_MUL]; // R12
			unit_divisor    <= nv_image[stop_cfg_pkg::NV_UNIT_DIV];
		end else if (wr_take) begin
			if (entry == stop_cfg_pkg::ENT_UNIT_MUL) begin
				unit_multiplier <= od_wdata; // R7
			end
			if (entry == stop_cfg_pkg::ENT_UNIT_DIV) begin
				unit_divisor <= od_wdata; // R7
			end
		end
	end

	// option code entries
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			qs_option  <= stop_cfg_pkg::RST_OPT; // R8
			sd_option  <= stop_cfg_pkg::RST_OPT; // R10
			dis_option <= stop_cfg_pkg::RST_OPT; // R11
		end else if (save_restore && restore_ok) begin
			qs_option  <= nv_image[stop_cfg_pkg::NV_QS_OPT][15:0]; // R12
			sd_option  <= nv_image[stop_cfg_pkg::NV_SD_OPT][15:0];
			dis_option <= nv_image[stop_cfg_pkg::NV_DIS_OPT][15:0];
		end else if (wr_take) begin
			if (entry == stop_cfg_pkg::ENT_QS_OPT) begin
				qs_option <= od_wdata[15:0]; // R8
			end
			if (entry == stop_cfg_pkg::ENT_SD_OPT) begin
				sd_option <= od_wdata[15:0]; // R10
			end
			if (entry == stop_cfg_pkg::ENT_DIS_OPT) begin
				dis_option <= od_wdata[15:0]; // R11
			end
		end
	end

	// non-volatile image, holds factory values until the first store
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			save_done <= 1'b0;
		end else begin
			save_done <= save_store || save_restore;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			nv_image[stop_cfg_pkg::NV_QS_SPEED] <= stop_cfg_pkg::RST_QS_SPEED;
			nv_image[stop_cfg_pkg::NV_QS_TIME]  <= {16'h0000, stop_cfg_pkg::RST_QS_TIME};
			nv_image[stop_cfg_pkg::NV_UNIT_MUL] <= stop_cfg_pkg::RST_UNIT_MUL;
			nv_image[stop_cfg_pkg::NV_UNIT_DIV] <= stop_cfg_pkg::RST_UNIT_DIV;
			nv_image[stop_cfg_pkg::NV_QS_OPT]   <= {16'h0000, stop_cfg_pkg::RST_OPT};
			nv_image[stop_cfg_pkg::NV_SD_OPT]   <= {16'h0000, stop_cfg_pkg::RST_OPT};
			nv_image[stop_cfg_pkg::NV_DIS_OPT]  <= {16'h0000, stop_cfg_pkg::RST_OPT};
		end else if (save_store && !save_restore) begin
			nv_image[stop_cfg_pkg::NV_QS_SPEED] <= qs_speed_step; // R12
			nv_image[stop_cfg_pkg::NV_QS_TIME]  <= {16'h0000, qs_time_step};
			nv_image[stop_cfg_pkg::NV_UNIT_MUL] <= unit_multiplier;
			nv_image[stop_cfg_pkg::NV_UNIT_DIV] <= unit_divisor;
			nv_image[stop_cfg_pkg::NV_QS_OPT]   <= {16'h0000, qs_option};
			nv_image[stop_cfg_pkg::NV_SD_OPT]   <= {16'h0000, sd_option};
			nv_image[stop_cfg_pkg::NV_DIS_OPT]  <= {16'h0000, dis_option};
		end
	end

	// read data; signed 16-bit options sign extend to the full word
	always_comb begin
		next_rdata = 32'h00000000;
		case (entry)
			stop_cfg_pkg::ENT_QS_COUNT:   next_rdata = {24'h000000, stop_cfg_pkg::ENTRY_COUNT};
			stop_cfg_pkg::ENT_QS_SPEED:   next_rdata = qs_speed_step;
			stop_cfg_pkg::ENT_QS_TIME:    next_rdata = {16'h0000, qs_time_step};
			stop_cfg_pkg::ENT_UNIT_COUNT: next_rdata = {24'h000000, stop_cfg_pkg::ENTRY_COUNT};
			stop_cfg_pkg::ENT_UNIT_MUL:   next_rdata = unit_multiplier;
			stop_cfg_pkg::ENT_UNIT_DIV:   next_rdata = unit_divisor;
			stop_cfg_pkg::ENT_QS_OPT:     next_rdata = {{16{qs_option[15]}}, qs_option};
			stop_cfg_pkg::ENT_SD_OPT:     next_rdata = {{16{sd_option[15]}}, sd_option};
			stop_cfg_pkg::ENT_DIS_OPT:    next_rdata = {{16{dis_option[15]}}, dis_option};
			default:                      next_rdata = 32'h00000000;
		endcase
	end

	// access answer one cycle after the request
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			od_ack   <= 1'b0;
			od_abort <= 1'b0;
			od_rdata <= 32'h00000000;
		end else begin
			od_ack   <= od_valid && (od_write ? wr_take : (entry != stop_cfg_pkg::ENT_NONE));
			od_abort <= od_valid && (od_write ? !wr_take : (entry == stop_cfg_pkg::ENT_NONE)); // R14
			if (od_valid && !od_write) begin
				od_rdata <= next_rdata;
			end
		end
	end

	// stop action selection on each power state machine transition
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stop_valid       <= 1'b0;
			stop_kind        <= stop_cfg_pkg::stop_immediate;
			stop_to_disabled <= 1'b0;
			decel_speed_step <= 32'h00000000;
			decel_time_step  <= 16'h0000;
		end else begin
			stop_valid <= psm_event && (psm_transition != 2'h3);
			if (psm_event) begin
				case (psm_transition)
					stop_cfg_pkg::TRANS_QUICKSTOP: begin
						stop_to_disabled <= (qs_option != stop_cfg_pkg::OPT_IMMEDIATE); // R9
						if (qs_option == stop_cfg_pkg::OPT_QUICK) begin
							stop_kind <= stop_cfg_pkg::stop_quick_ramp; // R9
							// velocity mode owns its quick-stop ramp, other modes supply theirs
							decel_speed_step <= velocity_mode ? qs_speed_step : mode_quick_speed; // R1
							decel_time_step  <= velocity_mode ? qs_time_step : mode_quick_time; // R2
						end else if (qs_option == stop_cfg_pkg::OPT_SLOW) begin
							stop_kind        <= stop_cfg_pkg::stop_slow_ramp; // R9
							decel_speed_step <= mode_slow_speed;
							decel_time_step  <= mode_slow_time;
						end else begin
							stop_kind        <= stop_cfg_pkg::stop_immediate; // R8
							decel_speed_step <= 32'h00000000;
							decel_time_step  <= 16'h0000;
						end
					end
					stop_cfg_pkg::TRANS_SHUTDOWN,
					stop_cfg_pkg::TRANS_DISABLE: begin
						// shutdown and disable share one code set
						if ((psm_transition == stop_cfg_pkg::TRANS_SHUTDOWN ? sd_option : dis_option)
							== stop_cfg_pkg::OPT_SLOW) begin
							stop_kind        <= stop_cfg_pkg::stop_slow_ramp; // R10 R13
							stop_to_disabled <= 1'b1;
							decel_speed_step <= mode_slow_speed;
							decel_time_step  <= mode_slow_time;
						end else begin
							stop_kind        <= stop_cfg_pkg::stop_immediate; // R10 R13
							stop_to_disabled <= 1'b0;
							decel_speed_step <= 32'h00000000;
							decel_time_step  <= 16'h0000;
						end
					end
					default: begin
						stop_kind <= stop_kind;
					end
				endcase
			end
		end
	end

	speed_unit_scale scaler (
		.clk        (clk),
		.reset_n    (reset_n),
		.start      (speed_start),
		.speed_in   (speed_internal),
		.multiplier (unit_multiplier),
		.divisor    (unit_divisor),
		.busy       (speed_busy),
		.done       (speed_valid),
		.result     (speed_user),
		.div_fault  (speed_fault),
		.in_rpm     (speed_in_rpm)
	);

endmodule

// file: verification/drive_stop_ramp_option_config_asserts.sv
// port-level checks of the stop ramp and option configuration block
`timescale 1ns/1ps
module drive_stop_ramp_option_config_asserts (
	input wire logic               clk,
	input wire logic               reset_n,
	input wire logic               od_valid,
	input wire logic               od_write,
	input wire logic [15:0]        od_index,
	input wire logic [7:0]         od_subindex,
	input wire logic [31:0]        od_wdata,
	input wire logic               od_ack,
	input wire logic               od_abort,
	input wire logic [31:0]        od_rdata,
	input wire logic               save_store,
	input wire logic               save_restore,
	input wire logic               save_done,
	input wire logic               psm_event,
	input wire logic [1:0]         psm_transition,
	input wire logic [31:0]        mode_slow_speed,
	input wire logic               stop_valid,
	input wire logic [1:0]         stop_kind,
	input wire logic               stop_to_disabled,
	input wire logic [31:0]        decel_speed_step,
	input wire logic [15:0]        decel_time_step,
	input wire logic               speed_start,
	input wire logic signed [31:0] speed_internal,
	input wire logic               speed_busy,
	input wire logic               speed_valid,
	input wire logic [31:0]        speed_user,
	input wire logic               speed_in_rpm
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	ack_once_a: assert property (od_valid |=> od_ack ^ od_abort)
		else $error("not one answer");
	idle_quiet_a: assert property (!od_valid |=> !(od_ack || od_abort))
		else $error("answer without access");
	rdata_hold_a: assert property (!(od_valid && !od_write) |=> $stable(od_rdata))
		else $error("rdata moved");
	reserved_refuse_a: assert property (od_valid && od_write && od_index == 16'h605B
		&& od_subindex == 8'h00 && od_wdata[15:0] > 16'h0001 |=> od_abort)
		else $error("reserved code taken");
	stop_answer_a: assert property (psm_event |=> stop_valid == ($past(psm_transition) != 2'h3))
		else $error("bad stop answer");
	immediate_flat_a: assert property (stop_valid && stop_kind == stop_cfg_pkg::stop_immediate
		|-> decel_speed_step == 32'h0 && decel_time_step == 16'h0 && !stop_to_disabled)
		else $error("immediate stop carries a ramp");
	slow_ramp_a: assert property (stop_valid && stop_kind == stop_cfg_pkg::stop_slow_ramp
		|-> decel_speed_step == $past(mode_slow_speed) && stop_to_disabled)
		else $error("bad slow ramp");
	rpm_bypass_a: assert property (speed_start && !speed_busy && speed_in_rpm
		|=> speed_valid && speed_user == $past(speed_internal))
		else $error("bad rpm bypass");
	conv_span_a: assert property ($rose(speed_busy)
		|-> ##64 speed_busy ##1 (!speed_busy && speed_valid))
		else $error("conversion length wrong");
	save_answer_a: assert property (save_store || save_restore |=> save_done)
		else $error("save not answered");
	cover property (psm_event && psm_transition == 2'h0);
	cover property (speed_valid && !speed_in_rpm);
	cover property (od_abort);
endmodule

// file: verification/od_master_model.sv
// fieldbus master model issuing single object dictionary accesses
`timescale 1ns/1ps
module od_master_model (
	input  wire logic        clk,
	input  wire logic        od_ack,
	input  wire logic        od_abort,
	input  wire logic [31:0] od_rdata,
	output logic             od_valid,
	output logic             od_write,
	output logic             od_pdo,
	output logic [15:0]      od_index,
	output logic [7:0]       od_subindex,
	output logic [31:0]      od_wdata
);
	initial begin
		{od_valid, od_write, od_pdo, od_index, od_subindex, od_wdata} = '0;
	end
	task automatic access(input logic wr, input logic pdo, input logic [15:0] idx,
			input logic [7:0] sub, input logic [31:0] wd, output logic ab,
			output logic [31:0] rd);
		@(negedge clk);
		{od_valid, od_write, od_pdo} = {1'b1, wr, pdo};
		{od_index, od_subindex, od_wdata} = {idx, sub, wd};
		@(negedge clk);
		ab = (od_ack ^ od_abort) ? od_abort : 1'bx;
		rd = od_rdata;
		// released qualifiers flip so a stale copy cannot pass
		{od_valid, od_write, od_pdo} = {1'b0, ~wr, ~pdo};
		{od_index, od_subindex, od_wdata} = ~{idx, sub, wd};
	endtask
endmodule

// file: verification/tb_drive_stop_ramp_option_config.sv
// self-checking bench for the stop ramp and option configuration block
`timescale 1ns/1ps
module tb_drive_stop_ramp_option_config;
	logic clk = 1'b0, reset_n = 1'b0, save_store = 1'b0, save_restore = 1'b0;
	logic psm_event = 1'b0, velocity_mode = 1'b0, speed_start = 1'b0;
	logic [1:0] psm_transition = 2'h0;
	logic [31:0] mode_slow_speed = 32'h0, mode_quick_speed = 32'h0;
	logic [15:0] mode_slow_time = 16'h0, mode_quick_time = 16'h0;
	logic signed [31:0] speed_internal = 32'h0;
	logic od_valid, od_write, od_pdo, od_ack, od_abort, save_done, stop_valid;
	logic stop_to_disabled, speed_busy, speed_valid, speed_fault, speed_in_rpm;
	logic [15:0] od_index, decel_time_step;
	logic [7:0] od_subindex;
	logic [31:0] od_wdata, od_rdata, decel_speed_step, speed_user;
	stop_cfg_pkg::stop_kind_type stop_kind;
	int n_errors = 0, compares = 0, cyc = 0;
	logic [31:0] rng = 32'h6C752D4E;
	logic [31:0] mdl [int], nv [int];
	always #2 clk = ~clk;
	drive_stop_ramp_option_config drive_stop_ramp_option_config_inst (.*);
	od_master_model od_master_model_inst (.*);
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("compares=%0d errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic acc(input logic wr, input logic pdo, input logic [15:0] idx,
			input logic [7:0] sub, input logic [31:0] wd);
		int k;
		logic ok, ab;
		logic [31:0] rd, v;
		k = {8'h00, idx, sub};
		v = (idx >= 16'h605A) ? {{16{wd[15]}}, wd[15:0]} : wd;
		if (k == 24'h604A02)
			v = {16'h0000, wd[15:0]};
		ok = mdl.exists(k) && !(wr && sub == 8'h00 && idx < 16'h605A);
		if (wr && idx >= 16'h605A)
			ok = ok && !pdo && $signed(v) >= 0 && $signed(v) <= ((idx == 16'h605A) ? 2 : 1);
		od_master_model_inst.access(wr, pdo, idx, sub, wd, ab, rd);
		chk(32'(ab), 32'(!ok));
		if (ok && wr)
			mdl[k] = v;
		if (!wr)
			chk(rd, ok ? mdl[k] : 32'h0);
	endtask
	task automatic stop(input int t);
		logic [31:0] o;
		@(negedge clk);
		psm_event = 1'b1;
		psm_transition = 2'(t);
		velocity_mode = 1'(xs());
		mode_slow_speed = xs();
		mode_slow_time = 16'(xs());
		mode_quick_speed = xs();
		mode_quick_time = 16'(xs());
		@(negedge clk);
		psm_event = 1'b0;
		o = (t < 3) ? mdl[24'h605A00 + t * 256] : 32'h0;
		chk(32'(stop_valid), 32'(t < 3));
		if (t < 3) begin
			chk(32'(stop_kind), o);
			chk(32'(stop_to_disabled), 32'(o != 0));
			chk(decel_speed_step, (o == 0) ? 32'h0 : (o == 1) ? mode_slow_speed :
				velocity_mode ? mdl[24'h604A01] : mode_quick_speed);
			chk(32'(decel_time_step), (o == 0) ? 32'h0 : (o == 1) ? 32'(mode_slow_time) :
				velocity_mode ? mdl[24'h604A02] : 32'(mode_quick_time));
		end
	endtask
	task automatic conv(input logic [31:0] vin);
		longint m, d, q;
		int n;
		logic fast;
		m = $signed(mdl[24'h604C01]);
		d = $signed(mdl[24'h604C02]);
		fast = (m == 1 && d == 1) || d == 0;
		q = (m == 1 && d == 1) ? longint'($signed(vin)) : (d == 0) ? 0 : $signed(vin) * m / d;
		@(negedge clk);
		speed_start = 1'b1;
		speed_internal = vin;
		n = 0;
		do begin
			@(negedge clk);
			speed_start = 1'b0;
			n++;
		end while (speed_valid !== 1'b1 && n < 100);
		chk(32'(n), fast ? 32'h1 : 32'h42);
		chk(speed_user, q[31:0]);
		chk(32'(speed_fault), 32'(d == 0));
		chk(32'(speed_in_rpm), 32'(m == 1 && d == 1));
	endtask
	task automatic sv(input logic st);
		@(negedge clk);
		save_store = st;
		save_restore = !st;
		@(negedge clk);
		save_store = 1'b0;
		save_restore = 1'b0;
		chk(32'(save_done), 32'h1);
		if (st)
			nv = mdl;
		else
			mdl = nv;
	endtask
	task automatic read_all();
		foreach (mdl[k])
			acc(1'b0, 1'b0, k[23:8], k[7:0], 32'h0);
	endtask
	// hang guard: whole run is a few hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		mdl[24'h604A00] = 32'h2;
		mdl[24'h604A01] = 32'h1388;
		mdl[24'h604A02] = 32'h1;
		mdl[24'h604C00] = 32'h2;
		mdl[24'h604C01] = 32'h1;
		mdl[24'h604C02] = 32'h3C;
		mdl[24'h605A00] = 32'h1;
		mdl[24'h605B00] = 32'h1;
		mdl[24'h605C00] = 32'h1;
		nv = mdl;
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		read_all();
		acc(1'b0, 1'b0, 16'h605D, 8'h00, 32'h0);
		acc(1'b0, 1'b0, 16'h604A, 8'h03, 32'h0);
		$display("test reset values done");
		acc(1'b1, 1'b1, 16'h604A, 8'h01, xs());
		acc(1'b1, 1'b1, 16'h604A, 8'h02, xs());
		acc(1'b1, 1'b0, 16'h604A, 8'h00, 32'h5);
		acc(1'b1, 1'b0, 16'h604C, 8'h00, 32'h5);
		acc(1'b1, 1'b1, 16'h605C, 8'h00, 32'h0);
		for (int i = 0; i < 15; i++) begin
			acc(1'b1, 1'b0, 16'h605A + 16'(i / 5), 8'h00, 32'(i % 5 - 1));
			acc(1'b0, 1'b0, 16'h605A + 16'(i / 5), 8'h00, 32'h0);
		end
		read_all();
		$display("test entry access done");
		for (int t = 0; t < 3; t++) begin
			for (int o = 0; o <= ((t == 0) ? 2 : 1); o++) begin
				acc(1'b1, 1'b0, 16'h605A + 16'(t), 8'h00, 32'(o));
				stop(t);
				stop(t);
			end
		end
		stop(3);
		$display("test stop selection done");
		conv(xs());
		acc(1'b1, 1'b0, 16'h604C, 8'h01, 32'h7);
		acc(1'b1, 1'b0, 16'h604C, 8'h02, 32'h3);
		conv(xs());
		acc(1'b1, 1'b0, 16'h604C, 8'h01, 32'hFFFFFFFB);
		conv(xs());
		acc(1'b1, 1'b0, 16'h604C, 8'h01, 32'h1);
		acc(1'b1, 1'b0, 16'h604C, 8'h02, 32'h1);
		conv(xs());
		acc(1'b1, 1'b0, 16'h604C, 8'h02, 32'h0);
		conv(xs());
		$display("test speed scaling done");
		acc(1'b1, 1'b0, 16'h605A, 8'h00, 32'h2);
		acc(1'b1, 1'b1, 16'h604A, 8'h01, xs());
		sv(1'b1);
		acc(1'b1, 1'b1, 16'h604A, 8'h01, xs());
		acc(1'b1, 1'b0, 16'h605A, 8'h00, 32'h0);
		sv(1'b0);
		read_all();
		$display("test save restore done");
		complete_run();
	end
endmodule
bind drive_stop_ramp_option_config drive_stop_ramp_option_config_asserts chk_inst (.*);
